// ---- hdl/bst_tap_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module bst_tap_top import bst_pkg::*; (
	// system clock and reset
	input wire logic MCLK_IN,
	input wire logic RESET_N_IN,
	input wire logic BSCAN_OPTION_EN_IN,
	// test port
	input wire logic TCK_IN,
	input wire logic TMS_IN,
	input wire logic TDI_IN,
	output logic TDO_OUT,
	output logic TDO_OE_OUT,
	// io blocks
	input wire logic [NUM_IOB-1:0] IOB_PAD_IN,
	input wire logic [NUM_IOB-1:0] IOB_CORE_OUT_IN,
	input wire logic [NUM_IOB-1:0] IOB_CORE_OE_IN,
	output logic [NUM_IOB-1:0] IOB_PAD_OUT,
	output logic [NUM_IOB-1:0] IOB_PAD_OE_OUT,
	output logic [NUM_IOB-1:0] IOB_CORE_IN_OUT,
	// mode select pins
	input wire logic MODE_SELECT_IN_LOW_IN,
	input wire logic MODE_SELECT_IN_HIGH_IN,
	input wire logic MODE_SELECT_OUT_MID_PAD_IN,
	input wire logic MODE_SELECT_OUT_MID_CORE_IN,
	input wire logic MODE_SELECT_OUT_MID_CORE_OE_IN,
	output logic MODE_SELECT_OUT_MID_OUT,
	output logic MODE_SELECT_OUT_MID_OE_OUT,
	// fabric user scan
	input wire logic USER_SERIAL_OUT_ONE_IN,
	input wire logic USER_SERIAL_OUT_TWO_IN,
	output logic USER_SELECT_ONE_OUT,
	output logic USER_SELECT_TWO_OUT,
	output logic EXPORTED_DR_CLOCK_OUT,
	output logic EXPORTED_IDLE_STROBE_OUT,
	output logic FINAL_UPDATE_CELL_OUT,
	output logic DR_SHIFT_OUT,
	output logic DR_UPDATE_OUT,
	// configuration unit
	input wire logic CFG_SERIAL_OUT_IN,
	input wire logic READBACK_DATA_IN,
	output logic CFG_LOAD_SELECT_OUT,
	output logic READBACK_SELECT_OUT
);
	bst_tap_state_t state_q, state_d;
	logic rst_s1_q, rst_s2_q, opt_s1_q, opt_s2_q;
	logic [BSR_LEN-1:0] cap_raw, cap_s1_q, cap_s2_q, cap_vec;
	logic [BSR_LEN-1:0] bsr_sh_q, bsr_sh_d, bsr_upd_q, bsr_upd_d;
	logic [IR_LEN-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
	logic byp_q, byp_d;
	logic sel1_q, sel1_d, sel2_q, sel2_d, cfg_sel_q, cfg_sel_d, rb_sel_q, rb_sel_d;
	logic ext_q, ext_d, pad_off_q, pad_off_d, shift_q, shift_d, upd_q, upd_d;
	logic tap_reset;
	logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d, rti_q, rti_d, drck_en_q, drck_en_d;
	logic upd_tgl_q, upd_tgl_d;

	function automatic bst_tap_state_t tap_next(input bst_tap_state_t s, input logic tms);
		case (s)
			TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET;
		endcase
	endfunction

	// raw capture sources; program, config clock and done pins have no cells
	always_comb begin
		cap_raw = '0;
		for (int i = 0; i < NUM_IOB; i++) begin
			cap_raw[bst_cell(i, OFS_IN)] = IOB_PAD_IN[i];
			cap_raw[bst_cell(i, OFS_OUT)] = IOB_CORE_OUT_IN[i];
			cap_raw[bst_cell(i, OFS_OE)] = IOB_CORE_OE_IN[i];
		end
		cap_raw[CELL_MODE_LOW] = MODE_SELECT_IN_LOW_IN;
		cap_raw[CELL_MODE_HIGH] = MODE_SELECT_IN_HIGH_IN;
		cap_raw[CELL_MODE_MID + OFS_IN] = MODE_SELECT_OUT_MID_PAD_IN;
		cap_raw[CELL_MODE_MID + OFS_OUT] = MODE_SELECT_OUT_MID_CORE_IN;
		cap_raw[CELL_MODE_MID + OFS_OE] = MODE_SELECT_OUT_MID_CORE_OE_IN;
	end

	// internal cells replace the synchronised pin values
	always_comb begin
		cap_vec = cap_s2_q;
		cap_vec[CELL_TDO_OE] = tdo_oe_q;
		cap_vec[CELL_TDO_DATA] = tdo_q;
		cap_vec[CELL_FINAL] = bsr_upd_q[CELL_FINAL];
	end

	// no reset pin: only system reset or option off force the reset state
	assign tap_reset = !rst_s2_q || !opt_s2_q;

	always_comb begin
		state_d = tap_reset ? TAP_RESET : tap_next(state_q, TMS_IN);
		ir_sh_d = ir_sh_q;
		ir_d = ir_q;
		bsr_sh_d = bsr_sh_q;
		bsr_upd_d = bsr_upd_q;
		byp_d = byp_q;
		case (state_q)
			TAP_RESET: begin
				ir_d = IR_RESET;
				bsr_upd_d = '0;
			end
			TAP_CAP_IR: ir_sh_d = IR_CAPTURE;
			TAP_SHIFT_IR: ir_sh_d = {TDI_IN, ir_sh_q[IR_LEN-1:1]};
			TAP_UPD_IR: ir_d = ir_sh_q;
			TAP_CAP_DR: begin
				byp_d = 1'h0;
				if (bst_is_bsr_instr(ir_q)) begin
					bsr_sh_d = cap_vec;
				end
			end
			TAP_SHIFT_DR: begin
				byp_d = TDI_IN;
				if (bst_is_bsr_instr(ir_q)) begin
					bsr_sh_d = {TDI_IN, bsr_sh_q[BSR_LEN-1:1]};
				end
			end
			TAP_UPD_DR: begin
				if (bst_is_bsr_instr(ir_q)) begin
					bsr_upd_d = bsr_sh_q;
				end
			end
			default: begin
			end
		endcase
		if (tap_reset) begin
			ir_d = IR_RESET;
			bsr_upd_d = '0;
		end
		// flips on each change of the update word outside test reset, which clears it, so the system side can take it once stable
		upd_tgl_d = !tap_reset && (upd_tgl_q ^ (bsr_upd_d != bsr_upd_q));
		sel1_d = (ir_d == INSTR_USER1);
		sel2_d = (ir_d == INSTR_USER2);
		cfg_sel_d = (ir_d == INSTR_CONFIGURE);
		rb_sel_d = (ir_d == INSTR_READBACK);
		ext_d = (ir_d == INSTR_EXTEST);
		pad_off_d = (ir_d == INSTR_CONFIGURE);
		shift_d = (state_d == TAP_SHIFT_DR);
		upd_d = (state_d == TAP_UPD_DR);
	end

	always_ff @(posedge TCK_IN) begin
		rst_s1_q <= RESET_N_IN;
		rst_s2_q <= rst_s1_q;
		opt_s1_q <= BSCAN_OPTION_EN_IN;
		opt_s2_q <= opt_s1_q;
		cap_s1_q <= cap_raw;
		cap_s2_q <= cap_s1_q;
		state_q <= state_d;
		ir_sh_q <= ir_sh_d;
		ir_q <= ir_d;
		bsr_sh_q <= bsr_sh_d;
		bsr_upd_q <= bsr_upd_d;
		upd_tgl_q <= upd_tgl_d;
		byp_q <= byp_d;
		sel1_q <= sel1_d;
		sel2_q <= sel2_d;
		cfg_sel_q <= cfg_sel_d;
		rb_sel_q <= rb_sel_d;
		ext_q <= ext_d;
		pad_off_q <= pad_off_d;
		shift_q <= shift_d;
		upd_q <= upd_d;
	end

	// falling-edge side: test output and exported strobes
	always_comb begin
		tdo_d = byp_q;
		case (state_q)
			TAP_SHIFT_IR: tdo_d = ir_sh_q[0];
			TAP_SHIFT_DR: begin
				case (ir_q)
					INSTR_EXTEST, INSTR_SAMPLE: tdo_d = bsr_sh_q[0];
					INSTR_USER1: tdo_d = USER_SERIAL_OUT_ONE_IN;
					INSTR_USER2: tdo_d = USER_SERIAL_OUT_TWO_IN;
					INSTR_READBACK: tdo_d = READBACK_DATA_IN;
					INSTR_CONFIGURE: tdo_d = CFG_SERIAL_OUT_IN;
					default: tdo_d = byp_q;
				endcase
			end
			default: tdo_d = byp_q;
		endcase
		tdo_oe_d = !tap_reset && ((state_q == TAP_SHIFT_IR) || (state_q == TAP_SHIFT_DR));
		rti_d = !tap_reset && (state_q == TAP_IDLE);
		drck_en_d = !tap_reset && (sel1_q || sel2_q) &&
			((state_q == TAP_CAP_DR) || (state_q == TAP_SHIFT_DR));
	end

	always_ff @(negedge TCK_IN) begin
		tdo_q <= tdo_d;
		tdo_oe_q <= tdo_oe_d;
		rti_q <= rti_d;
		drck_en_q <= drck_en_d;
	end

	assign TDO_OUT = tdo_q;
	assign TDO_OE_OUT = tdo_oe_q;
	assign USER_SELECT_ONE_OUT = sel1_q;
	assign USER_SELECT_TWO_OUT = sel2_q;
	assign FINAL_UPDATE_CELL_OUT = bsr_upd_q[CELL_FINAL];
	assign DR_SHIFT_OUT = shift_q;
	assign DR_UPDATE_OUT = upd_q;
	assign CFG_LOAD_SELECT_OUT = cfg_sel_q;
	assign READBACK_SELECT_OUT = rb_sel_q;
	// gated test clock, low while enable is low; enable changes only while the clock is low
	assign EXPORTED_DR_CLOCK_OUT = TCK_IN & drck_en_q;
	assign EXPORTED_IDLE_STROBE_OUT = ~(TCK_IN & rti_q);

	// system clock side: pad drive from update cells during extest
	logic [BSR_LEN-1:0] m_upd_q, m_upd_d;
	logic m_tgl_s1_q, m_tgl_s2_q, m_tgl_s3_q;
	logic m_ext_s1_q, m_ext_s2_q, m_off_s1_q, m_off_s2_q;
	logic [NUM_IOB-1:0] m_pad_s1_q, m_pad_s2_q;
	logic [NUM_IOB-1:0] pad_out_q, pad_out_d, pad_oe_q, pad_oe_d;
	logic mid_out_q, mid_out_d, mid_oe_q, mid_oe_d;

	always_comb begin
		// word is taken only after its toggle has crossed, or while the pads ignore it
		m_upd_d = m_upd_q;
		if ((m_tgl_s2_q != m_tgl_s3_q) || !m_ext_s2_q) begin
			m_upd_d = bsr_upd_q;
		end
		for (int i = 0; i < NUM_IOB; i++) begin
			pad_out_d[i] = m_ext_s2_q ? m_upd_q[bst_cell(i, OFS_OUT)] : IOB_CORE_OUT_IN[i];
			pad_oe_d[i] = !m_off_s2_q && (m_ext_s2_q ? m_upd_q[bst_cell(i, OFS_OE)] : IOB_CORE_OE_IN[i]);
		end
		mid_out_d = m_ext_s2_q ? m_upd_q[CELL_MODE_MID + OFS_OUT] : MODE_SELECT_OUT_MID_CORE_IN;
		mid_oe_d = !m_off_s2_q &&
			(m_ext_s2_q ? m_upd_q[CELL_MODE_MID + OFS_OE] : MODE_SELECT_OUT_MID_CORE_OE_IN);
		if (!RESET_N_IN) begin
			pad_out_d = '0;
			pad_oe_d = '0;
			mid_out_d = 1'h0;
			mid_oe_d = 1'h0;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		m_upd_q <= m_upd_d;
		m_tgl_s1_q <= upd_tgl_q;
		m_tgl_s2_q <= m_tgl_s1_q;
		m_tgl_s3_q <= m_tgl_s2_q;
		m_ext_s1_q <= ext_q;
		m_ext_s2_q <= m_ext_s1_q;
		m_off_s1_q <= pad_off_q;
		m_off_s2_q <= m_off_s1_q;
		m_pad_s1_q <= IOB_PAD_IN;
		m_pad_s2_q <= m_pad_s1_q;
		pad_out_q <= pad_out_d;
		pad_oe_q <= pad_oe_d;
		mid_out_q <= mid_out_d;
		mid_oe_q <= mid_oe_d;
	end

	assign IOB_PAD_OUT = pad_out_q;
	assign IOB_PAD_OE_OUT = pad_oe_q;
	assign IOB_CORE_IN_OUT = m_pad_s2_q;
	assign MODE_SELECT_OUT_MID_OUT = mid_out_q;
	assign MODE_SELECT_OUT_MID_OE_OUT = mid_oe_q;

	default clocking tck_cb @(posedge TCK_IN);
	endclocking
	default disable iff (!rst_s2_q);

	chk_tms_reset_seq: assert property (TMS_IN [*5] |=> state_q == TAP_RESET)
		else $error("five TMS highs did not reach reset");
	chk_option_off_reset: assert property (!opt_s2_q |=> state_q == TAP_RESET && !TDO_OE_OUT)
		else $error("disabled option did not hold controller in reset");
	chk_ir_capture_val: assert property (state_q == TAP_CAP_IR |=> ir_sh_q == IR_CAPTURE)
		else $error("instruction capture value wrong");
	chk_ir_reset_bypass: assert property (state_q == TAP_RESET |=> ir_q == IR_RESET)
		else $error("instruction not bypass after reset");
	chk_bypass_one_delay: assert property ((state_q == TAP_SHIFT_DR) |=> byp_q == $past(TDI_IN))
		else $error("bypass flop did not take test data in");
	chk_extest_pin_capture: assert property ((state_q == TAP_CAP_DR && ir_q == INSTR_EXTEST) |=>
		bsr_sh_q[bst_cell(0, OFS_IN)] == $past(cap_s2_q[bst_cell(0, OFS_IN)]) &&
		bsr_sh_q[CELL_MODE_MID + OFS_OE] == $past(cap_s2_q[CELL_MODE_MID + OFS_OE]))
		else $error("extest capture missed a pin cell");
	chk_tdo_cell_capture: assert property ((state_q == TAP_CAP_DR && bst_is_bsr_instr(ir_q)) |=>
		bsr_sh_q[CELL_TDO_OE] == $past(tdo_oe_q) && bsr_sh_q[CELL_TDO_DATA] == $past(tdo_q))
		else $error("test output cells not captured");
	chk_final_cell_update: assert property ((state_q == TAP_UPD_DR && bst_is_bsr_instr(ir_q)) |=>
		FINAL_UPDATE_CELL_OUT == $past(bsr_sh_q[CELL_FINAL]))
		else $error("final update cell not updated");
	chk_user_select_map: assert property (state_q == TAP_UPD_IR |=>
		USER_SELECT_ONE_OUT == ($past(ir_sh_q) == INSTR_USER1) &&
		USER_SELECT_TWO_OUT == ($past(ir_sh_q) == INSTR_USER2))
		else $error("user select does not follow instruction");
	chk_user_tdo_route: assert property (@(negedge TCK_IN) disable iff (!rst_s2_q)
		(state_q == TAP_SHIFT_DR && ir_q == INSTR_USER2) |=> TDO_OUT == $past(USER_SERIAL_OUT_TWO_IN))
		else $error("user serial data not on test output");
	chk_tdo_falling_ir: assert property (@(negedge TCK_IN) disable iff (!rst_s2_q)
		(state_q == TAP_SHIFT_IR) |=> TDO_OUT == $past(ir_sh_q[0]) && TDO_OE_OUT)
		else $error("instruction bit not driven on falling edge");
	chk_config_tdo_source: assert property (@(negedge TCK_IN) disable iff (!rst_s2_q)
		(state_q == TAP_SHIFT_DR && ir_q == INSTR_CONFIGURE) |=> TDO_OUT == $past(CFG_SERIAL_OUT_IN))
		else $error("configure output source wrong");

	cov_bypass_shift: cover property (state_q == TAP_SHIFT_DR && ir_q == INSTR_BYPASS);
	cov_user1_shift: cover property (state_q == TAP_SHIFT_DR && ir_q == INSTR_USER1);
	cov_extest_update: cover property (state_q == TAP_UPD_DR && ir_q == INSTR_EXTEST);
	cov_configure_sel: cover property (CFG_LOAD_SELECT_OUT);
endmodule // bst_tap_top
`default_nettype wire

// ---- hdl/bst_pkg.sv ----
`default_nettype none
package bst_pkg;
	// io blocks in this device and cell layout of the boundary register
	localparam int NUM_IOB = 4;
	localparam int CELLS_PER_IOB = 3;
	localparam int OFS_IN = 0;
	localparam int OFS_OUT = 1;
	localparam int OFS_OE = 2;
	localparam int CELL_TDO_OE = 0;
	localparam int CELL_TDO_DATA = 1;
	localparam int CELL_IOB_BASE = 2;
	localparam int CELL_MODE_LOW = CELL_IOB_BASE + CELLS_PER_IOB * NUM_IOB;
	localparam int CELL_MODE_HIGH = CELL_MODE_LOW + 1;
	localparam int CELL_MODE_MID = CELL_MODE_HIGH + 1;
	localparam int CELL_FINAL = CELL_MODE_MID + CELLS_PER_IOB;
	localparam int BSR_LEN = CELL_FINAL + 1;

	// instruction register
	localparam int IR_LEN = 3;
	localparam logic [IR_LEN-1:0] INSTR_EXTEST = 3'h0;
	localparam logic [IR_LEN-1:0] INSTR_SAMPLE = 3'h1;
	localparam logic [IR_LEN-1:0] INSTR_USER1 = 3'h2;
	localparam logic [IR_LEN-1:0] INSTR_USER2 = 3'h3;
	localparam logic [IR_LEN-1:0] INSTR_READBACK = 3'h4;
	localparam logic [IR_LEN-1:0] INSTR_CONFIGURE = 3'h5;
	localparam logic [IR_LEN-1:0] INSTR_RESERVED = 3'h6;
	localparam logic [IR_LEN-1:0] INSTR_BYPASS = 3'h7;
	localparam logic [IR_LEN-1:0] IR_CAPTURE = 3'h1;
	localparam logic [IR_LEN-1:0] IR_RESET = INSTR_BYPASS;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
		TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
		TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} bst_tap_state_t;

	// cell positions: in, out, enable inside each io block
	function automatic int bst_cell(input int blk, input int ofs);
		bst_cell = CELL_IOB_BASE + CELLS_PER_IOB * blk + ofs;
	endfunction

	function automatic logic bst_is_bsr_instr(input logic [IR_LEN-1:0] ir);
		bst_is_bsr_instr = (ir == INSTR_EXTEST) || (ir == INSTR_SAMPLE);
	endfunction
endpackage
`default_nettype wire

// ---- tb/bst_tester.sv ----
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
	// test port toward the device
	output logic TCK_OUT,
	output logic TMS_OUT,
	output logic TDI_OUT,
	input wire logic TDO_IN,
	// fabric strobes watched while the clock is high
	input wire logic IDLE_IN,
	input wire logic DRCK_IN
);
	logic tdo_q;
	logic idle_hi_q;
	logic drck_hi_q;
	initial begin
		TCK_OUT = 1'b0;
		TMS_OUT = 1'b1;
		TDI_OUT = 1'b0;
	end
	// one test clock: drive while low, take tdo just before the rising edge, return once the fall has settled
	task automatic step(input logic tms, input logic tdi);
		TMS_OUT = tms;
		TDI_OUT = tdi;
		#5;
		tdo_q = TDO_IN;
		TCK_OUT = 1'b1;
		#1;
		idle_hi_q = IDLE_IN;
		drck_hi_q = DRCK_IN;
		#5;
		TCK_OUT = 1'b0;
		#1;
	endtask
	// clock stands still between frames; released data line keeps moving
	task automatic park();
		TDI_OUT = ~TDI_OUT;
		#6;
	endtask
	// no reset pin: five high tms clocks reach test-logic-reset
	task automatic tlr();
		repeat (5) step(1'b1, 1'b0);
	endtask
endmodule // bst_tester
`default_nettype wire

// ---- tb/bst_tap_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module bst_tap_top_tb;
	import bst_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic opt_en = 1'b1;
	logic tck, tms, tdi, tdo, tdo_oe, drck, idle, fin, dsh, dup, sel1, sel2, cfg_sel, rb_sel, m_out, m_oe;
	logic [NUM_IOB-1:0] pad_in = 4'hA;
	logic [NUM_IOB-1:0] core_out = 4'h6;
	logic [NUM_IOB-1:0] core_oe = 4'hC;
	logic [NUM_IOB-1:0] pad_out, pad_oe, core_in;
	logic m_lo = 1'b1, m_hi = 1'b0, m_pad = 1'b1, m_core = 1'b0, m_coe = 1'b1;
	logic usr1 = 1'b0, usr2 = 1'b0, cfg_so = 1'b0, rb_d = 1'b0;
	logic drck_s, dsh_s, dup_s;
	int n_errors = 0;
	int n_tests = 0;
	always #5 mclk = ~mclk;
	bst_tester tst (.TCK_OUT(tck), .TMS_OUT(tms), .TDI_OUT(tdi), .TDO_IN(tdo), .IDLE_IN(idle), .DRCK_IN(drck));
	bst_tap_top dut (.MCLK_IN(mclk), .RESET_N_IN(rst_n), .BSCAN_OPTION_EN_IN(opt_en),
		.TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe),
		.IOB_PAD_IN(pad_in), .IOB_CORE_OUT_IN(core_out), .IOB_CORE_OE_IN(core_oe),
		.IOB_PAD_OUT(pad_out), .IOB_PAD_OE_OUT(pad_oe), .IOB_CORE_IN_OUT(core_in),
		.MODE_SELECT_IN_LOW_IN(m_lo), .MODE_SELECT_IN_HIGH_IN(m_hi), .MODE_SELECT_OUT_MID_PAD_IN(m_pad),
		.MODE_SELECT_OUT_MID_CORE_IN(m_core), .MODE_SELECT_OUT_MID_CORE_OE_IN(m_coe),
		.MODE_SELECT_OUT_MID_OUT(m_out), .MODE_SELECT_OUT_MID_OE_OUT(m_oe),
		.USER_SERIAL_OUT_ONE_IN(usr1), .USER_SERIAL_OUT_TWO_IN(usr2), .USER_SELECT_ONE_OUT(sel1),
		.USER_SELECT_TWO_OUT(sel2), .EXPORTED_DR_CLOCK_OUT(drck), .EXPORTED_IDLE_STROBE_OUT(idle),
		.FINAL_UPDATE_CELL_OUT(fin), .DR_SHIFT_OUT(dsh), .DR_UPDATE_OUT(dup),
		.CFG_SERIAL_OUT_IN(cfg_so), .READBACK_DATA_IN(rb_d), .CFG_LOAD_SELECT_OUT(cfg_sel),
		.READBACK_SELECT_OUT(rb_sel));
	// from run-test/idle through capture and shift of n bits, back to idle
	task automatic scan(input logic is_ir, input logic [19:0] v, input int n, output logic [19:0] o);
		o = '0;
		tst.step(1'b1, 1'b0);
		if (is_ir)
			tst.step(1'b1, 1'b0);
		tst.step(1'b0, 1'b0);
		tst.step(1'b0, 1'b0);
		for (int i = 0; i < n; i++) begin
			tst.step(i == n - 1, v[i]);
			o[i] = tst.tdo_q;
			if (i == 0) begin
				drck_s = tst.drck_hi_q;
				dsh_s = dsh;
			end
		end
		tst.step(1'b1, 1'b0);
		dup_s = dup;
		tst.step(1'b0, 1'b0);
		tst.park();
	endtask
	task automatic t_bypass();
		logic [19:0] o;
		scan(1'b0, 20'h0_00B5, 8, o);
		`CHK("bypass delay", 20'h0_006A, o)
		`CHK("tdo idle oe", 1'b0, tdo_oe)
		`CHK("dr shift strobe", 1'b1, dsh_s)
		`CHK("dr update strobe", 1'b1, dup_s)
		tst.step(1'b0, 1'b0);
		`CHK("idle strobe tck high", 1'b0, tst.idle_hi_q)
		`CHK("idle strobe tck low", 1'b1, idle)
	endtask
	task automatic t_instr();
		logic [19:0] o;
		logic [3:0] es;
		for (int k = 2; k < 8; k++) begin
			usr1 = (k == 2);
			usr2 = (k == 3);
			rb_d = (k == 4);
			cfg_so = (k == 5);
			scan(1'b1, 20'(k), IR_LEN, o);
			`CHK("ir capture", 20'(IR_CAPTURE), o)
			`CHK("no dr strobes in ir scan", 2'b00, {dsh_s, dup_s})
			es = '0;
			if (k <= 5)
				es[k-2] = 1'b1;
			`CHK("selects", es, {cfg_sel, rb_sel, sel2, sel1})
			scan(1'b0, 20'h0_0005, 4, o);
			`CHK("tdo source", (k < 6) ? 4'hF : 4'hA, o[3:0])
			`CHK("dr clock", (k == 2 || k == 3), drck_s)
			`CHK("pad enable source", (k == 5) ? 4'h0 : core_oe, pad_oe)
		end
		scan(1'b1, 20'(INSTR_USER1), IR_LEN, o);
		tst.tlr();
		tst.step(1'b0, 1'b0);
		`CHK("tms reset", 1'b0, sel1)
	endtask
	task automatic t_sample();
		logic [19:0] o;
		logic [19:0] e;
		scan(1'b1, 20'(INSTR_SAMPLE), IR_LEN, o);
		tst.step(1'b0, 1'b0);
		scan(1'b0, 20'h0_0000, BSR_LEN, o);
		e = '0;
		for (int i = 0; i < NUM_IOB; i++) begin
			e[2 + 3 * i] = pad_in[i];
			e[3 + 3 * i] = core_out[i];
			e[4 + 3 * i] = core_oe[i];
		end
		e[CELL_MODE_LOW] = m_lo;
		e[CELL_MODE_HIGH] = m_hi;
		e[CELL_MODE_MID] = m_pad;
		e[CELL_MODE_MID+1] = m_core;
		e[CELL_MODE_MID+2] = m_coe;
		`CHK("captured cells", e[18:2], o[18:2])
	endtask
	task automatic t_extest();
		logic [19:0] o;
		logic [19:0] p;
		p = '0;
		for (int i = 0; i < NUM_IOB; i++) begin
			p[3 + 3 * i] = (i == 0 || i == 2);
			p[4 + 3 * i] = (i == 0 || i == 3);
		end
		p[CELL_MODE_MID+1] = 1'b1;
		p[CELL_MODE_MID+2] = 1'b1;
		p[CELL_FINAL] = 1'b1;
		scan(1'b1, 20'(INSTR_EXTEST), IR_LEN, o);
		scan(1'b0, p, BSR_LEN, o);
		repeat (6) @(negedge mclk);
		`CHK("pad drive", 4'h5, pad_out)
		`CHK("pad enable", 4'h9, pad_oe)
		`CHK("mid drive", 2'b11, {m_out, m_oe})
		`CHK("final cell", 1'b1, fin)
		`CHK("pad to fabric", pad_in, core_in)
	endtask
	task automatic t_option();
		logic [19:0] o;
		@(negedge mclk);
		opt_en = 1'b0;
		scan(1'b1, 20'(INSTR_USER1), IR_LEN, o);
		`CHK("option off select", 1'b0, sel1)
		tst.step(1'b1, 1'b0);
		repeat (3) tst.step(1'b0, 1'b0);
		`CHK("option off oe", 1'b0, tdo_oe)
	endtask
	task automatic results();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		fork
			repeat (16) @(posedge mclk);
			repeat (12) tst.step(1'b1, 1'b0);
		join
		@(negedge mclk);
		rst_n = 1'b1;
		repeat (4) tst.step(1'b1, 1'b0);
		tst.step(1'b0, 1'b0);
		t_bypass();
		t_instr();
		t_sample();
		t_extest();
		t_option();
		results();
	end
endmodule // bst_tap_top_tb
`default_nettype wire
